// ### watch_timer.sv
// Watch timer and interval timer with Wishbone register access
// Operation
// RULE1: Reset clears the mode register to zero; timer stopped.
// RULE2: Bit 7 selects main clock divided by 128 or subsystem clock.
// RULE3: Bits 6..4 pick prescaler tap 2^4..2^9; codes 6 and 7 prohibited.
// RULE4: Bit 3 selects watch period of 2^14 or 2^5 timer clocks.
// RULE5: Bit 1 set starts the 5-bit counter; cleared stops and zeroes it.
// RULE6: Bit 0 enables prescaler; cleared clears prescaler and counter.
// RULE7: Watch counting and interrupt only while bits 0 and 1 both set.
// RULE8: Toggling bit 1 restarts counter at zero, prescaler keeps running.
// RULE9: Interval interrupt repeats at the tap while bit 0 is set.
// RULE10: Software stops the timer before changing bits 7..3.
// RULE11: Counter starts after one full prescaler cycle; first interrupt late.
// RULE12: Mode register accepts whole-byte and single-bit writes.
// RULE13: Watch and interval paths run together off one prescaler.
// RULE14: Bit 2 is unused, reads zero, ignores writes.
// RULE15: Each watch or interval request is a one-clock pulse.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "wt_map.svh"
module watch_timer #(
  parameter int AW = 18
) (
  // Clock and reset
  input  wire logic          CLK_I,
  input  wire logic          RESET_N_I,
  // Wishbone slave
  input  wire logic          CYC_I,
  input  wire logic          STB_I,
  input  wire logic          WE_I,
  input  wire logic [AW-1:0] ADR_I,
  input  wire logic [3:0]    SEL_I,
  input  wire logic [31:0]   DAT_I,
  output logic      [31:0]   DAT_O,
  output logic               ACK_O,
  // Subsystem clock pin
  input  wire logic          SUBCLK_I,
  // Interrupts
  output logic               WATCH_IRQ_O,
  output logic               INTERVAL_IRQ_O,
  output logic               IRQ_O
);
  import wt_pkg::*;

  localparam int PRE_W = `WT_PRE_W;

  wt_state_s            st;
  wt_state_s            nx;
  pre_out_s             pre;
  logic                 acc;
  logic                 wr;
  logic [15:0]          idx;
  logic [7:0]           wd;
  logic                 run;
  logic                 p9;
  logic                 p5;
  logic [3:0]           tap_len;
  logic [PRE_W-1:0]     tap_mask;
  logic                 intv_ok;
  logic                 intv_ev;
  logic                 watch_ev;
  logic [1:0]           clr_st;

  // Shared prescaler feeds both interrupt paths
  wt_prescaler u_pre ( // RULE13
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .subclk_i  (SUBCLK_I),
    .clk_sel_i (st.mode.count_clock_select),
    .enable_i  (st.mode.operation_enable),
    .pre_o     (pre)
  );

  // Bus decode
  assign acc = CYC_I & STB_I;
  assign wr  = acc & st.ack & WE_I & SEL_I[0];
  assign idx = ADR_I[AW-1:2];
  assign wd  = DAT_I[7:0];

  // Prescaler overflow points
  assign run = st.mode.operation_enable & st.mode.counter_run; // RULE7
  assign p9  = pre.tick & (&pre.value);
  assign p5  = pre.tick & (&pre.value[`WT_SHORT_TAP-1:0]);

  // Interval tap mask, one bit per prescaler stage
  assign tap_len = `WT_TAP_BASE + {1'b0, st.mode.interval_select};
  for (genvar i = 0; i < PRE_W; i++) begin : g_tap
    assign tap_mask[i] = (4'(i) < tap_len); // RULE3
  end
  assign intv_ok = st.mode.interval_select <= `WT_TAP_MAX; // RULE3

  // Interval event while enabled, regardless of counter control
  assign intv_ev = st.mode.operation_enable & intv_ok & pre.tick // RULE9
                 & ((pre.value & tap_mask) == tap_mask);

  // Watch event: counter overflow or short tap, once armed
  always_comb begin
    if (st.mode.watch_period_select) begin // RULE4
      watch_ev = run & st.armed & p5;
    end else begin
      watch_ev = run & st.armed & p9 & (&st.cnt);
    end
  end

  // Register file, counter and interrupts
  always_comb begin
    nx     = st;
    clr_st = 2'h0;
    nx.ack = acc & ~st.ack;
    // Writes land on the edge where the master samples ack
    if (wr) begin
      case (idx)
        `WT_MODE_IDX: nx.mode = mode_s'(wd & `WT_MODE_WMASK); // RULE12 RULE14
        `WT_SET_IDX:  nx.mode = mode_s'(st.mode | (wd & `WT_MODE_WMASK)); // RULE12
        `WT_CLR_IDX:  nx.mode = mode_s'(st.mode & ~wd); // RULE12
        `WT_STAT_IDX: clr_st  = wd[1:0];
        `WT_MASK_IDX: nx.mask = wd[1:0];
        default:      nx.mode = st.mode;
      endcase
    end
    // Read data captured when the request is accepted
    if (acc && !st.ack) begin
      case (idx)
        `WT_MODE_IDX: nx.dat = {24'h0, st.mode};
        `WT_SET_IDX:  nx.dat = {24'h0, st.mode};
        `WT_CLR_IDX:  nx.dat = {24'h0, st.mode};
        `WT_STAT_IDX: nx.dat = {30'h0, st.status};
        `WT_MASK_IDX: nx.dat = {30'h0, st.mask};
        `WT_CNT_IDX:  nx.dat = {26'h0, st.armed, st.cnt};
        `WT_PRE_IDX:  nx.dat = {23'h0, pre.value};
        default:      nx.dat = 32'h0;
      endcase
    end
    // Five-bit watch counter
    if (!run) begin // RULE5 RULE6 RULE7 RULE8
      nx.cnt   = '0;
      nx.armed = 1'b0;
    end else if (p9) begin
      if (!st.armed) begin // RULE11
        nx.armed = 1'b1;
      end else begin
        nx.cnt = st.cnt + 1'b1;
      end
    end
    // Sticky status, set wins over clear
    nx.status = (st.status & ~clr_st) | {intv_ev, watch_ev};
    nx.watch_p = watch_ev; // RULE15
    nx.intv_p  = intv_ev; // RULE15
    nx.irq     = |(nx.status & nx.mask);
  end

  // State register
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st      <= '0;
      st.mode <= mode_s'(`WT_MODE_RST); // RULE1
    end else begin
      st <= nx;
    end
  end

  // Outputs
  assign DAT_O          = st.dat;
  assign ACK_O          = st.ack;
  assign WATCH_IRQ_O    = st.watch_p;
  assign INTERVAL_IRQ_O = st.intv_p;
  assign IRQ_O          = st.irq;

  // First cycle after reset marker for checks
  logic rel_r;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rel_r <= 1'b0;
    end else begin
      rel_r <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence long_ovf_q;
    run && st.armed && p9 && (&st.cnt) && !st.mode.watch_period_select;
  endsequence

  sequence one_pulse_q;
    WATCH_IRQ_O ##1 !WATCH_IRQ_O;
  endsequence

  sequence set_en_q;
    acc && st.ack && WE_I && SEL_I[0] && idx == `WT_SET_IDX && wd[0];
  endsequence

  reset_mode_a: assert property (!rel_r |-> st.mode == 8'h00) // RULE1
    else $error("mode not zero after reset");
  stop_clear_a: assert property (!run |=> st.cnt == 0 && !st.armed) // RULE5
    else $error("counter not cleared when stopped");
  en_clear_a: assert property (!st.mode.operation_enable |=> pre.value == 0) // RULE6
    else $error("prescaler not cleared when disabled");
  first_skip_a: assert property (run && !st.armed && p9 |=> st.armed && st.cnt == 0) // RULE11
    else $error("first prescaler cycle not skipped");
  count_step_a: assert property (run && st.armed && p9 |=> // RULE7
    st.cnt == $past(st.cnt) + 5'h1) else $error("counter step wrong");
  watch_long_a: assert property (long_ovf_q |=> one_pulse_q) // RULE4
    else $error("watch pulse missing after overflow");
  watch_pulse_a: assert property (WATCH_IRQ_O |=> !WATCH_IRQ_O) // RULE15
    else $error("watch request longer than one clock");
  intv_stop_a: assert property (!st.mode.operation_enable |=> !INTERVAL_IRQ_O) // RULE9
    else $error("interval request while disabled");
  bad_code_a: assert property (st.mode.interval_select > 3'h5 |=> !INTERVAL_IRQ_O) // RULE3
    else $error("interval request on prohibited code");
  bit2_zero_a: assert property (!st.mode.unused) // RULE14
    else $error("unused mode bit set");
  set_bit_a: assert property (set_en_q |=> st.mode.operation_enable) // RULE12
    else $error("single bit set failed");
  restart_keep_a: assert property (st.mode.operation_enable && $fell(st.mode.counter_run) // RULE8
    && !pre.tick |-> pre.value == $past(pre.value)) else $error("prescaler disturbed");
endmodule

// ### watch_timer_tb.sv
// Self-checking bench for the watch and interval timer
`timescale 1ns/1ps
`include "wt_map.svh"
module watch_timer_tb;
  logic        CLK_I     = 1'b0;
  logic        RESET_N_I = 1'b0;
  logic        CYC_I     = 1'b0;
  logic        STB_I     = 1'b0;
  logic        WE_I      = 1'b0;
  logic [17:0] ADR_I     = 18'h0;
  logic [3:0]  SEL_I     = 4'h0;
  logic [31:0] DAT_I     = 32'h0;
  logic        SUBCLK_I  = 1'b0;
  logic [31:0] DAT_O;
  logic        ACK_O;
  logic        WATCH_IRQ_O;
  logic        INTERVAL_IRQ_O;
  logic        IRQ_O;
  logic [2:0]  sub_div   = 3'h0;
  logic [31:0] rd;
  int          n_errors  = 0;
  int          checks_done = 0;
  int          sub_edges = 0;
  int          cyc       = 0;
  int          e0;
  int          e1;

  // 200 MHz clock
  always #2.5 CLK_I = ~CLK_I;

  watch_timer #(.AW(18)) watch_timer_inst (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SUBCLK_I(SUBCLK_I), .WATCH_IRQ_O(WATCH_IRQ_O), .INTERVAL_IRQ_O(INTERVAL_IRQ_O),
    .IRQ_O(IRQ_O)
  );

  // Subsystem clock, 8 clocks per level, with rising-edge count
  always @(posedge CLK_I) begin
    cyc     <= cyc + 1;
    sub_div <= sub_div + 3'h1;
    if (sub_div == 3'h7) begin
      SUBCLK_I <= ~SUBCLK_I;
      if (SUBCLK_I == 1'b0) sub_edges <= sub_edges + 1;
    end
  end

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, waits for ack under a bound
  task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= {idx, 2'b00};
    SEL_I <= 4'h1;
    DAT_I <= {24'h0, wd};
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask

  // Wait for a watch (1) or interval (0) pulse under a bound
  task automatic wait_irq(input logic watch, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while ((watch ? WATCH_IRQ_O : INTERVAL_IRQ_O) !== 1'b1 && n < lim);
    if (n >= lim) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    bus(0, `WT_MODE_IDX, 8'h00); chk(rd, 32'h0);
    bus(0, `WT_STAT_IDX, 8'h00); chk(rd, 32'h0);
    bus(1, `WT_MODE_IDX, 8'h7e);
    bus(0, `WT_MODE_IDX, 8'h00); chk(rd, 32'h7a);
    bus(1, `WT_MODE_IDX, 8'h00);
    bus(1, `WT_SET_IDX, 8'h04);
    bus(1, `WT_SET_IDX, 8'h08);
    bus(0, `WT_MODE_IDX, 8'h00); chk(rd, 32'h08);
    bus(1, `WT_CLR_IDX, 8'h08);
    bus(0, `WT_MODE_IDX, 8'h00); chk(rd, 32'h0);
    bus(0, 16'hff50, 8'h00); chk(rd, 32'h0);
    $display("test registers done");
    // Interval taps from the subsystem clock, all codes
    for (int c = 0; c < 8; c++) begin
      bus(1, `WT_MODE_IDX, 8'h00);
      bus(1, `WT_STAT_IDX, 8'h03);
      bus(1, `WT_MODE_IDX, {1'b1, 3'(c), 4'h1});
      if (c < 6) begin
        wait_irq(0, (1 << (c + 4)) * 16 + 200);
        e0 = sub_edges;
        @(posedge CLK_I); chk(INTERVAL_IRQ_O, 1'b0);
        wait_irq(0, (1 << (c + 4)) * 16 + 200);
        chk(sub_edges - e0, 1 << (c + 4));
      end else begin
        repeat (600) @(posedge CLK_I);
        bus(0, `WT_STAT_IDX, 8'h00); chk(rd, 32'h0);
      end
    end
    chk(IRQ_O, 1'b0);
    $display("test interval taps done");
    // Main clock divided by 128
    bus(1, `WT_MODE_IDX, 8'h00);
    bus(1, `WT_MODE_IDX, 8'h01);
    wait_irq(0, 2300);
    e0 = cyc;
    wait_irq(0, 2300);
    chk(cyc - e0, 2048);
    $display("test main clock done");
    // Short watch period alongside the interval timer
    bus(1, `WT_MODE_IDX, 8'h00);
    bus(1, `WT_STAT_IDX, 8'h03);
    bus(1, `WT_MASK_IDX, 8'h01);
    bus(1, `WT_MODE_IDX, 8'h8b);
    e0 = sub_edges;
    wait_irq(1, 10000);
    e1 = sub_edges - e0;
    chk(32'(e1 >= 512 && e1 <= 548), 32'h1);
    e0 = sub_edges;
    wait_irq(1, 700);
    chk(sub_edges - e0, 32);
    bus(0, `WT_STAT_IDX, 8'h00); chk(rd, 32'h3);
    chk(IRQ_O, 1'b1);
    bus(1, `WT_CLR_IDX, 8'h02);
    bus(0, `WT_CNT_IDX, 8'h00); chk(rd, 32'h0);
    bus(1, `WT_SET_IDX, 8'h02);
    e0 = sub_edges;
    wait_irq(1, 10000);
    e1 = sub_edges - e0;
    chk(32'(e1 <= 548), 32'h1);
    bus(1, `WT_MODE_IDX, 8'h00);
    bus(0, `WT_PRE_IDX, 8'h00); chk(rd, 32'h0);
    bus(0, `WT_CNT_IDX, 8'h00); chk(rd, 32'h0);
    bus(1, `WT_STAT_IDX, 8'h03);
    bus(0, `WT_STAT_IDX, 8'h00); chk(rd, 32'h0);
    chk(IRQ_O, 1'b0);
    $display("test watch and interrupts done");
    close_out();
  end
endmodule

// ### wt_map.svh
// Register indices, field positions, reset values and counts of the watch timer
`ifndef WT_MAP_SVH
`define WT_MAP_SVH
// Register indices (byte address = index * 4)
`define WT_MODE_IDX   16'hff41
`define WT_SET_IDX    16'hff48
`define WT_CLR_IDX    16'hff49
`define WT_STAT_IDX   16'hff4a
`define WT_MASK_IDX   16'hff4b
`define WT_CNT_IDX    16'hff4c
`define WT_PRE_IDX    16'hff4d
// Mode register reset value and writable bits
`define WT_MODE_RST   8'h00
`define WT_MODE_WMASK 8'hfb
// Mode field positions
`define WT_CLKSEL_BIT 7
`define WT_INTV_LSB   4
`define WT_PERIOD_BIT 3
`define WT_RUN_BIT    1
`define WT_EN_BIT     0
// Interrupt status bit positions
`define WT_IRQ_WATCH  0
`define WT_IRQ_INTV   1
// Counts
`define WT_MAIN_DIV_W 7
`define WT_PRE_W      9
`define WT_CNT_W      5
`define WT_TAP_BASE   4'h4
`define WT_TAP_MAX    3'h5
`define WT_SHORT_TAP  5
`endif

// ### wt_pkg.sv
// Types shared by the watch timer modules
`include "wt_map.svh"
package wt_pkg;
  // Mode register layout
  typedef struct packed {
    logic       count_clock_select;
    logic [2:0] interval_select;
    logic       watch_period_select;
    logic       unused;
    logic       counter_run;
    logic       operation_enable;
  } mode_s;

  // Prescaler outputs handed to the main block
  typedef struct packed {
    logic                 tick;
    logic [`WT_PRE_W-1:0] value;
  } pre_out_s;

  // Prescaler state
  typedef struct packed {
    logic [`WT_MAIN_DIV_W-1:0] div;
    logic                      s1;
    logic                      s2;
    logic                      s3;
    logic                      tick;
    logic [`WT_PRE_W-1:0]      value;
  } pre_state_s;

  // Main block state
  typedef struct packed {
    mode_s                mode;
    logic [1:0]           status;
    logic [1:0]           mask;
    logic [`WT_CNT_W-1:0] cnt;
    logic                 armed;
    logic                 ack;
    logic [31:0]          dat;
    logic                 watch_p;
    logic                 intv_p;
    logic                 irq;
  } wt_state_s;
endpackage

// ### wt_prescaler.sv
// Timer clock selection and 9-bit prescaler of the watch timer
`timescale 1ns/1ps
module wt_prescaler (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Subsystem clock pin
  input  wire logic              subclk_i,
  // Control
  input  wire logic              clk_sel_i,
  input  wire logic              enable_i,
  // Prescaler outputs
  output wt_pkg::pre_out_s       pre_o
);
  import wt_pkg::*;

  pre_state_s st_r;
  pre_state_s st_nxt;

  // Timer tick from main divider or subsystem clock edge, then prescaler
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = subclk_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (!enable_i) begin // RULE6
      st_nxt.div   = '0;
      st_nxt.tick  = 1'b0;
      st_nxt.value = '0;
    end else begin
      st_nxt.div = st_r.div + 1'b1;
      if (clk_sel_i) begin // RULE2
        st_nxt.tick = st_r.s2 & ~st_r.s3;
      end else begin
        st_nxt.tick = &st_r.div;
      end
      if (st_r.tick) begin
        st_nxt.value = st_r.value + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pre_o.tick  = st_r.tick;
  assign pre_o.value = st_r.value;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Main clock tick spacing
  main_tick_a: assert property (st_r.tick && !clk_sel_i && enable_i |=> // RULE2
    !st_r.tick [*8]) else $error("main timer tick too close");
endmodule
